// *** pprx_map.vh ***
// Register map, field positions and constants of the packet receiver
`ifndef PPRX_MAP_VH
`define PPRX_MAP_VH

// Register offsets (byte addresses, one 32-bit word each)
`define PPRX_REG_CTRL     8'h00
`define PPRX_REG_CONF     8'h04
`define PPRX_REG_SYNC0    8'h08
`define PPRX_REG_SYNC1    8'h0C
`define PPRX_REG_SYNCLEN  8'h10
`define PPRX_REG_MAXLEN   8'h14
`define PPRX_REG_ADDR     8'h18
`define PPRX_REG_HDRCONF  8'h1C
`define PPRX_REG_ADRCONF  8'h20
`define PPRX_REG_QUEUE    8'h24
`define PPRX_REG_STATUS   8'h28
`define PPRX_REG_LIST     8'h40
`define PPRX_LIST_MASK    8'hE0

// Control register bits
`define PPRX_CT_STD       0
`define PPRX_CT_ADV       1
`define PPRX_CT_STOP      2

// Configuration register bits
`define PPRX_CF_VARLEN    0
`define PPRX_CF_ADRCHK    1
`define PPRX_CF_FILTER    2
`define PPRX_CF_CRCEN     3
`define PPRX_CF_CRCSW     4
`define PPRX_CF_CRCHDR    5
`define PPRX_CF_WHITEN    6
`define PPRX_CF_APPEND    7
`define PPRX_CF_STOREHDR  8
`define PPRX_CF_MSBFIRST  9

// Header configuration fields (lsb positions)
`define PPRX_HC_HBITS     0
`define PPRX_HC_LW        6
`define PPRX_HC_LPOS      11
`define PPRX_HC_OFF       16

// Address configuration fields (lsb positions)
`define PPRX_AC_TYPE      0
`define PPRX_AC_SIZE      1
`define PPRX_AC_POS       7
`define PPRX_AC_NUM       12

// Reset values
`define PPRX_RST_CONF     32'h0000_0209
`define PPRX_RST_SLEN     6'h20

// Outcome codes
`define PPRX_RES_OK       2'h0
`define PPRX_RES_CRCERR   2'h1
`define PPRX_RES_IGNORED  2'h2
`define PPRX_RES_ABORT    2'h3

// Check polynomial, check word seed and whitening seed
`define PPRX_CRC_POLY     16'h1021
`define PPRX_CRC_INIT     16'hFFFF
`define PPRX_PN9_INIT     9'h1FF

`endif

// *** pprx_core.v ***
// Receive-side packet parser for the proprietary radio receive modes
`timescale 1ns/100ps
`include "pprx_map.vh"

// Function
// - Standard mode matches sync pattern in low bits of one sync setting
// - Variable length: byte after sync is length; over maximum restarts hunt
// - Fixed length: exactly maximum bytes between sync and check word
// - Address byte checked against both values, plus 0x00 when second is 0xFF
// - Mismatch: option 0 restarts hunt, option 1 receives but marks ignored
// - Null queue pointer: packets processed but never written to buffer
// - Standard check covers length, address and payload; disabled means good
// - Standard dewhitening of length, payload and check word before checking
// - Standard status index 0..3 per matched value; sync identifier always 0
// - Advanced mode also hunts second pattern when nonzero and modem allows
// - Advanced header of up to 32 bits, stored rounded up to whole bytes
// - Length field extracted, offset added, accepted only if within maximum
// - Address inside header by bit position or trailing 1 to 8 bytes
// - Sync identifier bit prepended as address MSB under dual-sync conditions
// - Address list scanned; entry width smallest of 8/16/32/64 that fits
// - Header stored least significant byte first; payload in arrival order
// - Advanced check covers sync and header only when selected; payload always
// - Advanced header dewhitened only when covered; payload and check always
// - Advanced status index is first matching entry; identifier marks pattern
// - Result field: 0 good, 1 check error, 2 ignored, 3 aborted or full
// - Zero maximum length means unlimited length, ended by stop, address drop or full buffer
module pprx_core (
	// Clock and reset
	input  wire        SYS_CLK,
	input  wire        RST_N,
	// Register port
	input  wire [7:0]  REG_ADDR,
	input  wire [31:0] REG_WDATA,
	input  wire        REG_WR,
	input  wire        REG_RD,
	output reg  [31:0] REG_RDATA,
	// Modem bit stream
	input  wire        RX_BIT,
	input  wire        RX_BIT_VALID,
	input  wire        DUAL_SYNC_OK,
	// Receive buffer
	input  wire        BUF_SPACE,
	output reg         BUF_WR,
	output reg  [7:0]  BUF_WDATA,
	// Packet outcome
	output reg         PKT_DONE,
	output reg  [1:0]  PKT_RESULT
);

	localparam ST_IDLE = 6'h01;
	localparam ST_HUNT = 6'h02;
	localparam ST_HDR  = 6'h04;
	localparam ST_PAY  = 6'h08;
	localparam ST_CRC  = 6'h10;
	localparam ST_STAT = 6'h20;

	// Configuration registers
	reg [31:0] conf_ff, sync0_ff, sync1_ff, hdrc_ff, aconf_ff, queue_ff;
	reg [5:0]  slen_ff;
	reg [7:0]  max_ff, adr0_ff, adr1_ff;
	reg [63:0] list_ff [0:3];
	// Receive state
	reg [5:0]  st_ff, hcnt_ff;
	reg        adv_ff, sid_ff, ign_ff, unl_ff, wrote_ff;
	reg [31:0] sreg_ff, hdr_ff;
	reg [15:0] crc_ff;
	reg [8:0]  pn_ff;
	reg [7:0]  byte_ff, len_ff, pcnt_ff, cnt_ff;
	reg [2:0]  bcnt_ff, hst_left_ff, hst_idx_ff;
	reg [1:0]  idx_ff, lres_ff, lidx_ff;
	reg        lsid_ff;
	reg [63:0] addr_ff;
	integer    i, j;

	// Configuration fields
	wire       var_len   = conf_ff[`PPRX_CF_VARLEN];
	wire       addr_chk  = conf_ff[`PPRX_CF_ADRCHK];
	wire       filt_op   = conf_ff[`PPRX_CF_FILTER];
	wire       crc_en    = conf_ff[`PPRX_CF_CRCEN];
	wire       whiten_en = conf_ff[`PPRX_CF_WHITEN];
	wire       append_en = conf_ff[`PPRX_CF_APPEND];
	wire       msb_first = conf_ff[`PPRX_CF_MSBFIRST];
	wire [5:0] hc_hbits  = hdrc_ff[`PPRX_HC_HBITS +: 6];
	wire [4:0] ac_pos    = aconf_ff[`PPRX_AC_POS +: 5];
	wire [5:0] ac_size   = aconf_ff[`PPRX_AC_SIZE +: 6];
	wire [2:0] ac_num    = aconf_ff[`PPRX_AC_NUM +: 3];

	// Standard mode is mapped onto the advanced packet structure
	wire [5:0] e_hbits = adv_ff ? (hc_hbits > 6'h20 ? 6'h20 : hc_hbits) :
		((var_len && max_ff != 8'h00) ? 6'h08 : 6'h00);
	wire [4:0] e_lw     = adv_ff ? hdrc_ff[`PPRX_HC_LW +: 5] : (e_hbits != 6'h00 ? 5'h08 : 5'h00);
	wire [4:0] e_lpos   = adv_ff ? hdrc_ff[`PPRX_HC_LPOS +: 5] : 5'h00;
	wire [7:0] e_off    = adv_ff ? hdrc_ff[`PPRX_HC_OFF +: 8] : 8'h00;
	wire e_crc_hdr      = adv_ff ? conf_ff[`PPRX_CF_CRCHDR] : 1'b1;
	wire e_store_hdr    = adv_ff ? conf_ff[`PPRX_CF_STOREHDR] : 1'b1;
	wire e_atype        = adv_ff & aconf_ff[`PPRX_AC_TYPE];
	wire [5:0] e_asize  = adv_ff ? ac_size : {5'h00, addr_chk};
	wire use_sb         = adv_ff && sync1_ff != 32'h0 &&
		(aconf_ff[`PPRX_AC_TYPE] || ac_pos != 5'h00);
	wire can_store      = queue_ff != 32'h0;

	// Sync hunt over the last received bits
	wire [31:0] sreg_n = {sreg_ff[30:0], RX_BIT};
	wire [31:0] smask  = (slen_ff >= 6'h20) ? 32'hFFFFFFFF : ~(32'hFFFFFFFF << slen_ff[4:0]);
	// Count widened so that a saturated hunt counter still allows a match
	wire in_hunt = (st_ff == ST_HUNT) && RX_BIT_VALID &&
		({1'b0, hcnt_ff} + 7'h01 >= {1'b0, slen_ff});
	wire hit0 = in_hunt && (((sreg_n ^ sync0_ff) & smask) == 32'h0);
	wire hit1 = in_hunt && adv_ff && sync1_ff != 32'h0 && DUAL_SYNC_OK &&
		(((sreg_n ^ sync1_ff) & smask) == 32'h0);
	wire hit  = hit0 | hit1;

	// Per-bit dewhitening and check word update
	wire in_hdr   = st_ff == ST_HDR;
	wire in_pay   = st_ff == ST_PAY;
	wire bit_v    = RX_BIT_VALID && (in_hdr || in_pay || st_ff == ST_CRC);
	wire white_on = whiten_en && (in_hdr ? e_crc_hdr : 1'b1);
	wire db       = RX_BIT ^ (white_on & pn_ff[0]);
	wire crc_on   = in_hdr ? e_crc_hdr : 1'b1;
	wire [15:0] crc_step = {crc_ff[14:0], 1'b0} ^
		((crc_ff[15] ^ db) ? `PPRX_CRC_POLY : 16'h0000);
	wire [8:0] pn_step = {pn_ff[0] ^ pn_ff[5], pn_ff[8:1]};

	// Header assembly and end of header
	wire [31:0] hdr_n = msb_first ? {hdr_ff[30:0], db} : (hdr_ff | ({31'h0, db} << hcnt_ff[4:0]));
	wire hdr_last = in_hdr && RX_BIT_VALID && (hcnt_ff + 6'h01 == e_hbits);
	wire hdr_done = hdr_last || (hit && e_hbits == 6'h00);
	wire [31:0] hdr_fin = in_hdr ? hdr_n : 32'h0;
	wire [2:0] hdr_bytes = e_hbits[5:3] + {2'b00, e_hbits[2:0] != 3'h0};

	// Length field, offset and limit
	wire [31:0] lf    = (hdr_fin >> e_lpos) & ~(32'hFFFFFFFF << e_lw);
	wire [33:0] lsum  = {2'b00, lf} + {{26{e_off[7]}}, e_off};
	wire len_bad = e_lw != 5'h00 && max_ff != 8'h00 &&
		(lsum[33] || lsum[32:0] > {25'h0, max_ff});
	wire [7:0] len_val = (e_lw != 5'h00) ? lsum[7:0] : max_ff;

	// Payload byte assembly
	wire [7:0] byte_n   = msb_first ? {byte_ff[6:0], db} : {db, byte_ff[7:1]};
	wire pay_byte = in_pay && RX_BIT_VALID && bcnt_ff == 3'h7;
	wire trail_end = pay_byte && !e_atype && e_asize != 6'h00 &&
		(pcnt_ff + 8'h01 == {2'b00, e_asize});
	wire hdr_chk = hdr_done && e_atype && e_asize != 6'h00;
	wire ck = hdr_chk || trail_end;

	// Address value, width and comparison
	reg [63:0] a_raw, a_full, emask;
	reg [6:0]  a_bits, tot;
	reg        amatch, found;
	reg [1:0]  aidx;
	always @* begin
		a_raw = hdr_chk ? {32'h0, (hdr_fin >> ac_pos) & ~(32'hFFFFFFFF << ac_size[4:0])} :
			{addr_ff[55:0], byte_n};
		a_bits = hdr_chk ? {1'b0, e_asize} : {e_asize[3:0], 3'b000};
		a_full = a_raw | ((use_sb && sid_ff) ? (64'h1 << a_bits) : 64'h0);
		tot = a_bits + {6'h00, use_sb};
		if (tot <= 7'h08) begin
			emask = 64'h00000000000000FF;
		end else if (tot <= 7'h10) begin
			emask = 64'h000000000000FFFF;
		end else if (tot <= 7'h20) begin
			emask = 64'h00000000FFFFFFFF;
		end else begin
			emask = 64'hFFFFFFFFFFFFFFFF;
		end
		found = 1'b0;
		aidx = 2'h0;
		if (adv_ff) begin
			for (i = 3; i >= 0; i = i - 1) begin
				if (i < ac_num && (list_ff[i] & emask) == a_full) begin
					found = 1'b1;
					aidx = i[1:0];
				end
			end
		end else if (a_raw[7:0] == adr0_ff) begin
			found = 1'b1;
			aidx = 2'h0;
		end else if (adr1_ff == 8'hFF && a_raw[7:0] == 8'h00) begin
			found = 1'b1;
			aidx = 2'h2;
		end else if (adr1_ff == 8'hFF && a_raw[7:0] == 8'hFF) begin
			found = 1'b1;
			aidx = 2'h3;
		end else if (a_raw[7:0] == adr1_ff) begin
			found = 1'b1;
			aidx = 2'h1;
		end
		amatch = found;
	end
	wire drop = ck && !amatch && !filt_op;
	wire ign  = ck && !amatch && filt_op;

	// Buffer write requests
	wire stop_cmd = REG_WR && REG_ADDR == `PPRX_REG_CTRL && REG_WDATA[`PPRX_CT_STOP];
	wire in_pkt   = !(st_ff == ST_IDLE || st_ff == ST_HUNT);
	wire crc_good = !crc_en || crc_ff == 16'h0000;
	wire [1:0] res_n = !crc_good ? `PPRX_RES_CRCERR :
		(ign_ff ? `PPRX_RES_IGNORED : `PPRX_RES_OK);
	wire stat_go  = st_ff == ST_STAT && hst_left_ff == 3'h0;
	wire wr_stat  = append_en && can_store && stat_go;
	wire wr_stop  = append_en && can_store && stop_cmd && in_pkt && wrote_ff;
	wire wr_hst   = hst_left_ff != 3'h0;
	wire wr_pay   = pay_byte && can_store && !drop;
	wire wr_any   = wr_stat || wr_stop || wr_hst || wr_pay;
	wire full     = wr_any && !BUF_SPACE && !stop_cmd;
	wire [7:0] hst_byte = hdr_ff[{hst_idx_ff[1:0], 3'b000} +: 8];
	wire [7:0] stat_byte = {(wr_stop ? `PPRX_RES_ABORT : res_n), sid_ff, 3'b000,
		(ck ? aidx : idx_ff)};

	// Register writes
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			conf_ff  <= `PPRX_RST_CONF;
			sync0_ff <= 32'h0;
			sync1_ff <= 32'h0;
			hdrc_ff  <= 32'h0;
			aconf_ff <= 32'h0;
			queue_ff <= 32'h0;
			slen_ff  <= `PPRX_RST_SLEN;
			max_ff   <= 8'h00;
			adr0_ff  <= 8'h00;
			adr1_ff  <= 8'h00;
			for (j = 0; j < 4; j = j + 1) begin
				list_ff[j] <= 64'h0;
			end
		end else if (REG_WR) begin
			if (REG_ADDR == `PPRX_REG_CONF) begin
				conf_ff <= REG_WDATA;
			end else if (REG_ADDR == `PPRX_REG_SYNC0) begin
				sync0_ff <= REG_WDATA;
			end else if (REG_ADDR == `PPRX_REG_SYNC1) begin
				sync1_ff <= REG_WDATA;
			end else if (REG_ADDR == `PPRX_REG_SYNCLEN) begin
				slen_ff <= REG_WDATA[5:0];
			end else if (REG_ADDR == `PPRX_REG_MAXLEN) begin
				max_ff <= REG_WDATA[7:0];
			end else if (REG_ADDR == `PPRX_REG_ADDR) begin
				adr0_ff <= REG_WDATA[7:0];
				adr1_ff <= REG_WDATA[15:8];
			end else if (REG_ADDR == `PPRX_REG_HDRCONF) begin
				hdrc_ff <= REG_WDATA;
			end else if (REG_ADDR == `PPRX_REG_ADRCONF) begin
				aconf_ff <= REG_WDATA;
			end else if (REG_ADDR == `PPRX_REG_QUEUE) begin
				queue_ff <= REG_WDATA;
			end else if ((REG_ADDR & `PPRX_LIST_MASK) == `PPRX_REG_LIST) begin
				if (REG_ADDR[2]) begin
					list_ff[REG_ADDR[4:3]][63:32] <= REG_WDATA;
				end else begin
					list_ff[REG_ADDR[4:3]][31:0] <= REG_WDATA;
				end
			end
		end
	end

	// Register reads, data stand one cycle after the strobe
	reg [31:0] rd_n;
	always @* begin
		rd_n = 32'h0;
		if (REG_ADDR == `PPRX_REG_CTRL) begin
			rd_n = {26'h0, st_ff};
		end else if (REG_ADDR == `PPRX_REG_CONF) begin
			rd_n = conf_ff;
		end else if (REG_ADDR == `PPRX_REG_SYNC0) begin
			rd_n = sync0_ff;
		end else if (REG_ADDR == `PPRX_REG_SYNC1) begin
			rd_n = sync1_ff;
		end else if (REG_ADDR == `PPRX_REG_SYNCLEN) begin
			rd_n = {26'h0, slen_ff};
		end else if (REG_ADDR == `PPRX_REG_MAXLEN) begin
			rd_n = {24'h0, max_ff};
		end else if (REG_ADDR == `PPRX_REG_ADDR) begin
			rd_n = {16'h0, adr1_ff, adr0_ff};
		end else if (REG_ADDR == `PPRX_REG_HDRCONF) begin
			rd_n = hdrc_ff;
		end else if (REG_ADDR == `PPRX_REG_ADRCONF) begin
			rd_n = aconf_ff;
		end else if (REG_ADDR == `PPRX_REG_QUEUE) begin
			rd_n = queue_ff;
		end else if (REG_ADDR == `PPRX_REG_STATUS) begin
			rd_n = {16'h0, cnt_ff, 3'h0, lidx_ff, lsid_ff, lres_ff};
		end else if ((REG_ADDR & `PPRX_LIST_MASK) == `PPRX_REG_LIST) begin
			rd_n = REG_ADDR[2] ? list_ff[REG_ADDR[4:3]][63:32] : list_ff[REG_ADDR[4:3]][31:0];
		end
	end
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h0;
		end else begin
			REG_RDATA <= REG_RD ? rd_n : 32'h0;
		end
	end

	// Check word seeded with the matched sync pattern when selected
	function [15:0] crc_pat;
		input [31:0] pat;
		input [5:0]  len;
		integer      k;
		reg   [15:0] c;
		begin
			c = `PPRX_CRC_INIT;
			for (k = 31; k >= 0; k = k - 1) begin
				if (k < len) begin
					c = {c[14:0], 1'b0} ^ ((c[15] ^ pat[k]) ? `PPRX_CRC_POLY : 16'h0000);
				end
			end
			crc_pat = c;
		end
	endfunction

	// Receive sequencer, buffer writes and outcome reporting
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_ff <= ST_IDLE;
			hcnt_ff <= 6'h00;
			adv_ff <= 1'b0;
			sid_ff <= 1'b0;
			ign_ff <= 1'b0;
			unl_ff <= 1'b0;
			wrote_ff <= 1'b0;
			sreg_ff <= 32'h0;
			hdr_ff <= 32'h0;
			crc_ff <= `PPRX_CRC_INIT;
			pn_ff <= `PPRX_PN9_INIT;
			byte_ff <= 8'h00;
			len_ff <= 8'h00;
			pcnt_ff <= 8'h00;
			cnt_ff <= 8'h00;
			bcnt_ff <= 3'h0;
			hst_left_ff <= 3'h0;
			hst_idx_ff <= 3'h0;
			idx_ff <= 2'h0;
			lres_ff <= 2'h0;
			lidx_ff <= 2'h0;
			lsid_ff <= 1'b0;
			addr_ff <= 64'h0;
			BUF_WR <= 1'b0;
			BUF_WDATA <= 8'h00;
			PKT_DONE <= 1'b0;
			PKT_RESULT <= 2'h0;
		end else begin
			BUF_WR <= wr_any && BUF_SPACE;
			BUF_WDATA <= (wr_stat || wr_stop) ? stat_byte : (wr_hst ? hst_byte : byte_n);
			PKT_DONE <= 1'b0;
			if (wr_any && BUF_SPACE) begin
				wrote_ff <= 1'b1;
			end
			if (wr_hst && BUF_SPACE) begin
				hst_left_ff <= hst_left_ff - 3'h1;
				hst_idx_ff <= hst_idx_ff + 3'h1;
			end
			// Start of a receive command
			if (st_ff == ST_IDLE && REG_WR && REG_ADDR == `PPRX_REG_CTRL &&
				(REG_WDATA[`PPRX_CT_STD] || REG_WDATA[`PPRX_CT_ADV])) begin
				adv_ff <= REG_WDATA[`PPRX_CT_ADV];
				st_ff <= ST_HUNT;
				hcnt_ff <= 6'h00;
			end
			if (st_ff == ST_HUNT && RX_BIT_VALID) begin
				sreg_ff <= sreg_n;
				if (hcnt_ff < 6'h3F) begin
					hcnt_ff <= hcnt_ff + 6'h01;
				end
			end
			// Sync found
			if (hit) begin
				sid_ff <= !hit0;
				crc_ff <= conf_ff[`PPRX_CF_CRCSW] && adv_ff ?
					crc_pat(hit0 ? sync0_ff : sync1_ff, slen_ff) : `PPRX_CRC_INIT;
				pn_ff <= `PPRX_PN9_INIT;
				hdr_ff <= 32'h0;
				hcnt_ff <= 6'h00;
				ign_ff <= 1'b0;
				idx_ff <= 2'h0;
				wrote_ff <= 1'b0;
				hst_left_ff <= 3'h0;
				st_ff <= ST_HDR;
			end
			// Bits of header, payload and check word
			if (bit_v) begin
				if (white_on) begin
					pn_ff <= pn_step;
				end
				if (crc_on) begin
					crc_ff <= crc_step;
				end
				hcnt_ff <= hcnt_ff + 6'h01;
			end
			if (in_hdr && RX_BIT_VALID) begin
				hdr_ff <= hdr_n;
			end
			if (in_pay && RX_BIT_VALID) begin
				byte_ff <= byte_n;
				bcnt_ff <= bcnt_ff + 3'h1;
			end
			if (st_ff == ST_CRC && RX_BIT_VALID && hcnt_ff == 6'h0F) begin
				st_ff <= ST_STAT;
			end
			// End of header: length, header address and header storage
			if (hdr_done) begin
				len_ff <= len_val;
				unl_ff <= max_ff == 8'h00;
				ign_ff <= ign;
				idx_ff <= hdr_chk ? aidx : 2'h0;
				hst_left_ff <= (e_store_hdr && can_store) ? hdr_bytes : 3'h0;
				hst_idx_ff <= 3'h0;
				pcnt_ff <= 8'h00;
				bcnt_ff <= 3'h0;
				addr_ff <= 64'h0;
				hcnt_ff <= 6'h00;
				if (max_ff != 8'h00 && len_val == 8'h00) begin
					st_ff <= crc_en ? ST_CRC : ST_STAT;
				end else begin
					st_ff <= ST_PAY;
				end
			end
			// Completed payload byte
			if (pay_byte) begin
				pcnt_ff <= pcnt_ff + 8'h01;
				if (!e_atype && pcnt_ff < {2'b00, e_asize}) begin
					addr_ff <= {addr_ff[55:0], byte_n};
				end
				if (trail_end) begin
					ign_ff <= ign;
					idx_ff <= aidx;
				end
				if (!unl_ff && pcnt_ff + 8'h01 == len_ff) begin
					st_ff <= crc_en ? ST_CRC : ST_STAT;
					hcnt_ff <= 6'h00;
				end
			end
			// Packet finished
			if (stat_go) begin
				PKT_DONE <= 1'b1;
				PKT_RESULT <= res_n;
				lres_ff <= res_n;
				lsid_ff <= sid_ff;
				lidx_ff <= idx_ff;
				cnt_ff <= cnt_ff + 8'h01;
				st_ff <= ST_HUNT;
				hcnt_ff <= 6'h00;
			end
			// Illegal length, dropped address or no buffer space
			if ((hdr_done && len_bad) || drop || full) begin
				PKT_DONE <= 1'b1;
				PKT_RESULT <= `PPRX_RES_ABORT;
				lres_ff <= `PPRX_RES_ABORT;
				hst_left_ff <= 3'h0;
				st_ff <= ST_HUNT;
				hcnt_ff <= 6'h00;
			end
			// Stop command ends everything
			if (stop_cmd && st_ff != ST_IDLE) begin
				if (in_pkt) begin
					PKT_DONE <= 1'b1;
					PKT_RESULT <= `PPRX_RES_ABORT;
					lres_ff <= `PPRX_RES_ABORT;
				end
				hst_left_ff <= 3'h0;
				st_ff <= ST_IDLE;
			end
		end
	end

endmodule

// *** pprx_monitor.sv ***
// Port-level checker of the packet receiver, bound to its top module
`timescale 1ns/100ps
`include "pprx_map.vh"
module pprx_monitor (
	// Clock and reset
	input wire        SYS_CLK,
	input wire        RST_N,
	// Register port
	input wire [7:0]  REG_ADDR,
	input wire [31:0] REG_WDATA,
	input wire        REG_WR,
	// Buffer and outcome
	input wire        BUF_SPACE,
	input wire        BUF_WR,
	input wire [7:0]  BUF_WDATA,
	input wire        PKT_DONE,
	input wire [1:0]  PKT_RESULT
);
	logic [9:0] conf_ff;
	logic [7:0] max_ff;
	logic [7:0] cnt_ff;
	logic       null_ff;
	logic       std_ff;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// Shadow of the settings that the checks depend on
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			conf_ff <= 10'h209;
			max_ff <= 8'h00;
			null_ff <= 1'b1;
			std_ff <= 1'b0;
		end else if (REG_WR) begin
			if (REG_ADDR == `PPRX_REG_CONF) conf_ff <= REG_WDATA[9:0];
			if (REG_ADDR == `PPRX_REG_MAXLEN) max_ff <= REG_WDATA[7:0];
			if (REG_ADDR == `PPRX_REG_QUEUE) null_ff <= (REG_WDATA == 32'h0);
			if (REG_ADDR == `PPRX_REG_CTRL && REG_WDATA[`PPRX_CT_STD]) std_ff <= 1'b1;
			if (REG_ADDR == `PPRX_REG_CTRL && REG_WDATA[`PPRX_CT_ADV]) std_ff <= 1'b0;
		end
	end
	// Counts data bytes stored since the last outcome
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) cnt_ff <= 8'h00;
		else if (PKT_DONE) cnt_ff <= 8'h00;
		else if (BUF_WR) cnt_ff <= cnt_ff + 8'h01;
	end
	done_pulse_a: assert property (PKT_DONE |=> !PKT_DONE)
		else $error("outcome pulse longer than one cycle");
	space_gate_a: assert property (BUF_WR |-> $past(BUF_SPACE))
		else $error("byte stored without buffer space");
	null_queue_a: assert property (null_ff && $past(null_ff) |-> !BUF_WR)
		else $error("byte stored with null queue");
	status_field_a: assert property (PKT_DONE && BUF_WR |->
		BUF_WDATA[7:6] == PKT_RESULT && BUF_WDATA[4:2] == 3'h0)
		else $error("status byte result field wrong");
	std_syncid_a: assert property (std_ff && PKT_DONE && BUF_WR |-> !BUF_WDATA[5])
		else $error("standard status sync id not zero");
	std_index_a: assert property (std_ff && !conf_ff[1] && PKT_DONE && BUF_WR |->
		BUF_WDATA[1:0] == 2'h0)
		else $error("index not zero with address check off");
	crc_off_a: assert property (PKT_DONE && !conf_ff[3] |-> PKT_RESULT != 2'h1)
		else $error("check error reported with check off");
	filter_drop_a: assert property (PKT_DONE && !conf_ff[2] |-> PKT_RESULT != 2'h2)
		else $error("ignored result with filter option 0");
	fixed_count_a: assert property (std_ff && !conf_ff[0] && !null_ff && PKT_DONE &&
		PKT_RESULT == 2'h0 |-> cnt_ff == max_ff)
		else $error("fixed length byte count wrong");
endmodule
bind pprx_core pprx_monitor pprx_monitor_inst (.SYS_CLK, .RST_N, .REG_ADDR, .REG_WDATA,
	.REG_WR, .BUF_SPACE, .BUF_WR, .BUF_WDATA, .PKT_DONE, .PKT_RESULT);

// *** pprx_modem.sv ***
// Modem model that delivers demodulated bits to the packet receiver
`timescale 1ns/100ps
module pprx_modem (
	// Clock
	input  wire  clk,
	// Bit stream
	output logic rx_bit,
	output logic rx_valid
);
	int gap;
	// Idle stream at start
	initial begin
		gap = 0;
		rx_bit = 1'b0;
		rx_valid = 1'b0;
	end
	// Sends the low n bits of v, first the most significant; unqualified cycles invert the line
	task automatic send(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk);
			rx_bit <= v[i];
			rx_valid <= 1'b1;
			repeat (gap) begin
				@(posedge clk);
				rx_valid <= 1'b0;
				rx_bit <= ~v[i];
			end
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_bit <= ~rx_bit;
	endtask
endmodule

// *** pprx_core_tb.sv ***
// Self-checking testbench of the packet receiver
`timescale 1ns/100ps
`include "pprx_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module pprx_core_tb;
	logic        SYS_CLK = 1'b0;
	logic        RST_N = 1'b0;
	logic [7:0]  REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic [31:0] REG_RDATA;
	logic        RX_BIT;
	logic        RX_BIT_VALID;
	logic        DUAL_SYNC_OK = 1'b0;
	logic        BUF_SPACE = 1'b1;
	logic        BUF_WR;
	logic [7:0]  BUF_WDATA;
	logic        PKT_DONE;
	logic [1:0]  PKT_RESULT;
	logic [1:0]  res;
	logic [15:0] crc;
	logic [7:0]  got[$];
	logic [7:0]  want[$];
	logic [7:0]  body[$];
	int          dones;
	int          error_cnt = 0;
	int          n_compared = 0;
	always #50 SYS_CLK = ~SYS_CLK;
	pprx_core pprx_core_inst (.SYS_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
		.REG_RDATA, .RX_BIT, .RX_BIT_VALID, .DUAL_SYNC_OK, .BUF_SPACE, .BUF_WR, .BUF_WDATA,
		.PKT_DONE, .PKT_RESULT);
	pprx_modem pprx_modem_inst (.clk(SYS_CLK), .rx_bit(RX_BIT), .rx_valid(RX_BIT_VALID));
	// Collects stored bytes and packet outcomes
	always @(posedge SYS_CLK) begin
		if (BUF_WR === 1'b1) got.push_back(BUF_WDATA);
		if (PKT_DONE === 1'b1) begin
			res = PKT_RESULT;
			dones++;
		end
	end
	// Check word over one byte, first bit most significant
	function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `PPRX_CRC_POLY : 16'h0);
		return c;
	endfunction
	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		@(negedge SYS_CLK);
		`CHK(REG_RDATA, e)
	endtask
	// Frame pieces: preamble and sync, bytes, check word
	task automatic frame(input logic [31:0] s);
		got.delete();
		dones = 0;
		pprx_modem_inst.send(32'h55, 8);
		pprx_modem_inst.send(s, 16);
		crc = `PPRX_CRC_INIT;
	endtask
	task automatic burst();
		foreach (body[i]) begin
			pprx_modem_inst.send({24'h0, body[i]}, 8);
			crc = crc8(crc, body[i]);
		end
	endtask
	task automatic crcs(input logic [15:0] bad);
		pprx_modem_inst.send({16'h0, crc ^ bad}, 16);
	endtask
	// Waits for the outcome and compares it with the stored bytes
	task automatic fin(input logic [1:0] r, input string nm);
		for (int i = 0; i < 300 && dones == 0; i++) @(posedge SYS_CLK);
		repeat (2) @(posedge SYS_CLK);
		`CHK(dones, 1)
		`CHK(res, r)
		`CHK(got.size(), want.size())
		foreach (want[i]) `CHK(got[i], want[i])
		$display("test %s done", nm);
	endtask
	// Reset values and the idle state
	task automatic t_regs();
		rd(`PPRX_REG_CONF, 32'h209);
		rd(`PPRX_REG_SYNCLEN, 32'h20);
		rd(`PPRX_REG_QUEUE, 32'h0);
		rd(8'h3C, 32'h0);
		rd(`PPRX_REG_CTRL, 32'h1);
		$display("test regs done");
	endtask
	// Fixed length standard packet with good or broken check word
	task automatic t_fixed(input logic [15:0] bad, input logic [1:0] r, input logic [7:0] st);
		frame(32'hA5C3);
		body = '{8'h11, 8'h22, 8'h33};
		burst();
		crcs(bad);
		want = '{8'h11, 8'h22, 8'h33, st};
		fin(r, "fixed");
	endtask
	// Variable length: too long, then accepted addresses
	task automatic t_varlen();
		wr(`PPRX_REG_CONF, 32'h28B);
		wr(`PPRX_REG_ADDR, 32'hFF12);
		frame(32'hA5C3);
		body = '{8'h09};
		burst();
		want.delete();
		fin(2'h3, "too long");
		for (int k = 0; k < 2; k++) begin
			frame(32'hA5C3);
			body = '{8'h02, k ? 8'h00 : 8'h12, 8'h44};
			burst();
			crcs(16'h0);
			want = '{8'h02, body[1], 8'h44, k ? 8'h02 : 8'h00};
			fin(2'h0, "address");
		end
	endtask
	// Address mismatch under both filter options
	task automatic t_filter();
		frame(32'hA5C3);
		body = '{8'h02, 8'h77};
		burst();
		want = '{8'h02};
		fin(2'h3, "drop");
		wr(`PPRX_REG_CONF, 32'h28F);
		frame(32'hA5C3);
		body = '{8'h02, 8'h77, 8'h44};
		burst();
		crcs(16'h0);
		want = '{8'h02, 8'h77, 8'h44, 8'h80};
		fin(2'h2, "ignored");
	endtask
	// Null queue with check off, then a buffer without space
	task automatic t_nullq();
		wr(`PPRX_REG_QUEUE, 32'h0);
		wr(`PPRX_REG_CONF, 32'h280);
		frame(32'hA5C3);
		body = '{8'h11, 8'h22, 8'h33};
		burst();
		crcs(16'hBEEF);
		want.delete();
		fin(2'h0, "null queue");
		wr(`PPRX_REG_QUEUE, 32'h100);
		wr(`PPRX_REG_CONF, 32'h288);
		BUF_SPACE <= 1'b0;
		frame(32'hA5C3);
		body = '{8'h11};
		burst();
		fin(2'h3, "full");
		BUF_SPACE <= 1'b1;
	endtask
	// Advanced receive on the second pattern with a 12-bit header
	task automatic t_adv();
		wr(`PPRX_REG_CTRL, 32'h4);
		wr(`PPRX_REG_SYNC1, 32'h3C96);
		wr(`PPRX_REG_HDRCONF, 32'h10C);
		wr(`PPRX_REG_ADRCONF, 32'h0);
		wr(`PPRX_REG_MAXLEN, 32'h8);
		wr(`PPRX_REG_CONF, 32'h388);
		DUAL_SYNC_OK <= 1'b1;
		pprx_modem_inst.gap = 2;
		wr(`PPRX_REG_CTRL, 32'h2);
		frame(32'h3C96);
		pprx_modem_inst.send(32'hAB2, 12);
		body = '{8'h5A, 8'h6B};
		burst();
		crcs(16'h0);
		want = '{8'hB2, 8'h0A, 8'h5A, 8'h6B, 8'h20};
		fin(2'h0, "advanced");
		// Header address with sync bit on top; only the second list entry holds it
		wr(`PPRX_REG_LIST, 32'hB);
		wr(8'h48, 32'h1B);
		wr(`PPRX_REG_ADRCONF, 32'h2209);
		frame(32'h3C96);
		pprx_modem_inst.send(32'hAB2, 12);
		burst();
		crcs(16'h0);
		want[4] = 8'h21;
		fin(2'h0, "list");
		rd(`PPRX_REG_STATUS, 32'h80C);
	endtask
	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		t_regs();
		wr(`PPRX_REG_SYNC0, 32'hA5C3);
		wr(`PPRX_REG_SYNCLEN, 32'h10);
		wr(`PPRX_REG_QUEUE, 32'h100);
		wr(`PPRX_REG_MAXLEN, 32'h3);
		wr(`PPRX_REG_CONF, 32'h288);
		wr(`PPRX_REG_CTRL, 32'h1);
		t_fixed(16'h0, 2'h0, 8'h00);
		t_fixed(16'h1, 2'h1, 8'h40);
		t_varlen();
		t_filter();
		t_nullq();
		t_adv();
		conclude();
	end
	// Watchdog against a hang
	initial begin
		#3000000;
		error_cnt++;
		conclude();
	end
endmodule
